// >>> dss_pkg.sv
// Purpose: Shared constants and types for the dual supply sequencer
// Assumes: 200 MHz clock, comparator results arrive as digital levels
// Notes:   Long counts are also top-level parameters so simulation can shorten them
package dss_pkg;

  // ---------------------------------------------------------------------------
  // Clock and times
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned FILT_DEEP_NS    = 20000;
  localparam int unsigned FILT_SHALLOW_NS = 80000;
  localparam int unsigned BRK_QUAL_NS     = 1500;
  localparam int unsigned TIMER_PERIOD_US = 200000;

  // Rejection times are longest times: round down
  localparam int unsigned FILT_DEEP_CYC    = (FILT_DEEP_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned FILT_SHALLOW_CYC = (FILT_SHALLOW_NS * 1000) / CLK_PERIOD_PS;
  // Qualification is a least time: round up
  localparam int unsigned BRK_QUAL_CYC     = (BRK_QUAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint unsigned TIMER_CYC    = (64'(TIMER_PERIOD_US) * 64'd1000000) / 64'(CLK_PERIOD_PS);

  localparam int unsigned CNT_W = 32;

  // ---------------------------------------------------------------------------
  // Synchroniser bit positions
  // ---------------------------------------------------------------------------
  localparam int unsigned SYN_ON_HARD  = 0;
  localparam int unsigned SYN_ON_LOW   = 1;
  localparam int unsigned SYN_ON_HIGH  = 2;
  localparam int unsigned SYN_SNS_OK   = 3;
  localparam int unsigned SYN_SNS_DEEP = 4;
  localparam int unsigned SYN_CUR1     = 5;
  localparam int unsigned SYN_CUR2     = 6;
  localparam int unsigned SYN_SUPPLY   = 7;
  localparam int unsigned SYN_N        = 8;
  localparam logic [SYN_N-1:0] SYN_RST = 8'h00;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    DRV_OFF_FAST,
    DRV_RAMP_DOWN,
    DRV_RAMP_UP
  } dss_drive_t;

  typedef enum logic [1:0] {
    GATE_IDLE,
    GATE_WAIT,
    GATE_ON
  } dss_gate_t;

endpackage : dss_pkg

// >>> dss_tmr_if.sv
// Purpose: Link between the sequencer and the shared delay timer
// Assumes: One clock domain
// Notes:   clear wins over counting
`timescale 1ns/1ps
interface dss_tmr_if;
  logic clear;
  logic done;

  modport ctl (output clear, input done);
  modport tmr (input clear, output done);
endinterface : dss_tmr_if

// >>> dss_timer.sv
// Purpose: Shared delay timer, one cycle of PERIOD clocks
// Assumes: Controller holds clear while no delay is wanted
// Notes:   done is a one-cycle pulse at end of cycle
`timescale 1ns/1ps
module dss_timer
  import dss_pkg::*;
#(
  parameter longint unsigned PERIOD = TIMER_CYC
)(
  input  wire logic clk,
  input  wire logic nrst,
  dss_tmr_if.tmr    tif
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             done;
  logic             next_done;

  always_comb
  begin
    next_count = count + 32'h1;
    next_done  = 1'b0;
    if (tif.clear)
    begin
      next_count = '0;
    end
    else if (count == CNT_W'(PERIOD - 1))
    begin
      next_count = '0;
      next_done  = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count <= '0;
      done  <= 1'b0;
    end
    else
    begin
      count <= next_count;
      done  <= next_done;
    end
  end

  assign tif.done = done;

endmodule : dss_timer

// >>> dss_glitch_filter.sv
// Purpose: Glitch filter on the output-sense comparator
// Assumes: Inputs already synchronised
// Notes:   Only falls are filtered; rises pass at once, the timer delays them
`timescale 1ns/1ps
module dss_glitch_filter
  import dss_pkg::*;
#(
  parameter int unsigned DEEP_CYC    = FILT_DEEP_CYC,
  parameter int unsigned SHALLOW_CYC = FILT_SHALLOW_CYC
)(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic sense_ok,
  input  wire logic dip_deep,
  output logic      filt_ok
);

  logic [CNT_W-1:0] low_cnt;
  logic [CNT_W-1:0] next_low_cnt;
  logic             next_filt_ok;
  logic [CNT_W-1:0] limit;

  always_comb
  begin
    limit        = dip_deep ? CNT_W'(DEEP_CYC) : CNT_W'(SHALLOW_CYC);
    next_low_cnt = '0;
    next_filt_ok = 1'b1;
    if (!sense_ok)
    begin
      next_filt_ok = filt_ok;
      if (low_cnt + 32'h1 >= limit)
      begin
        next_filt_ok = 1'b0;
        next_low_cnt = low_cnt;
      end
      else
      begin
        next_low_cnt = low_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      low_cnt <= '0;
      filt_ok <= 1'b0;
    end
    else
    begin
      low_cnt <= next_low_cnt;
      filt_ok <= next_filt_ok;
    end
  end

endmodule : dss_glitch_filter

// >>> dss_sequencer.sv
// Purpose: Two-channel supply switch sequencing, reset delay and breaker
// Assumes: Comparators arrive as asynchronous digital levels, one free clock
// Notes:   Drive codes tell the analog gate stage which current to apply
//
// Behaviour
// - At power-up both channel drives are held off.
// - Channel 1 ramps up after control stays above low threshold one timer cycle.
// - Channel 2 ramps up above high threshold once that cycle has completed.
// - Below a channel threshold but above hard-off, that channel ramps down gently.
// - Sense rising starts a timer cycle; reset releases when it completes.
// - Sense falling passes the glitch filter, then reset goes low.
// - Sense high for less than a cycle keeps reset low, delay abandoned.
// - Dips rejected: 20 us when deeper than 150 mV, 80 us when shallow.
// - Timer held at zero when idle, counts to end, pulses, clears.
// - One shared timer serves gate turn-on and reset release delays.
// - Breaker trips when either current sense exceeds trip level beyond qualification.
// - A trip forces both drives fully off at once.
// - Control below hard-off then high clears breaker and starts a new cycle.
// - After a clear, drives return when the new timer cycle completes.
// - Control below hard-off forces both drives off immediately.
// - Fault output low while tripped, released when control is taken low.
// - Supply under lockout disables everything: drives off, reset low.
`timescale 1ns/1ps
module dss_sequencer
  import dss_pkg::*;
#(
  parameter longint unsigned TIMER_CYCLES   = TIMER_CYC,
  parameter int unsigned     FILT_SHORT_CYC = FILT_DEEP_CYC,
  parameter int unsigned     FILT_LONG_CYC  = FILT_SHALLOW_CYC,
  parameter int unsigned     QUAL_CYC       = BRK_QUAL_CYC
)(
  input  wire logic CLK_I,
  input  wire logic NRST_I,
  input  wire logic ON_HARD_I,
  input  wire logic ON_LOW_I,
  input  wire logic ON_HIGH_I,
  input  wire logic OUTPUT_SENSE_INPUT_I,
  input  wire logic SENSE_DIP_DEEP_I,
  input  wire logic CURRENT_MONITOR_INPUT1_I,
  input  wire logic CURRENT_MONITOR_INPUT2_I,
  input  wire logic SUPPLY_RAIL_OK_I,
  output dss_drive_t CHANNEL1_DRIVE_O,
  output dss_drive_t CHANNEL2_DRIVE_O,
  output logic      RESET_N_O,
  output logic      FAULT_N_O
);

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  logic [SYN_N-1:0] raw;
  logic [SYN_N-1:0] syn_a;
  logic [SYN_N-1:0] syn;

  assign raw = {SUPPLY_RAIL_OK_I, CURRENT_MONITOR_INPUT2_I, CURRENT_MONITOR_INPUT1_I, SENSE_DIP_DEEP_I,
                OUTPUT_SENSE_INPUT_I, ON_HIGH_I, ON_LOW_I, ON_HARD_I};

  genvar gi;
  generate
    for (gi = 0; gi < SYN_N; gi++)
    begin : g_sync
      always_ff @(posedge CLK_I or negedge NRST_I)
      begin
        if (!NRST_I)
        begin
          syn_a[gi] <= SYN_RST[gi];
          syn[gi]   <= SYN_RST[gi];
        end
        else
        begin
          syn_a[gi] <= raw[gi];
          syn[gi]   <= syn_a[gi];
        end
      end
    end
  endgenerate

  logic on_hard;
  logic on_low;
  logic on_high;
  logic supply_ok;
  logic over_cur;

  assign on_hard   = syn[SYN_ON_HARD];
  assign on_low    = syn[SYN_ON_LOW] & on_hard;
  assign on_high   = syn[SYN_ON_HIGH] & on_low;
  assign supply_ok = syn[SYN_SUPPLY];
  assign over_cur  = syn[SYN_CUR1] | syn[SYN_CUR2];

  // ---------------------------------------------------------------------------
  // Glitch filter and shared timer
  // ---------------------------------------------------------------------------
  logic sense_filt;

  dss_glitch_filter #(
    .DEEP_CYC    (FILT_SHORT_CYC),
    .SHALLOW_CYC (FILT_LONG_CYC)
  ) u_filter (
    .clk      (CLK_I),
    .nrst     (NRST_I),
    .sense_ok (syn[SYN_SNS_OK]),
    .dip_deep (syn[SYN_SNS_DEEP]),
    .filt_ok  (sense_filt)
  );

  dss_tmr_if tif ();

  dss_timer #(
    .PERIOD (TIMER_CYCLES)
  ) u_timer (
    .clk  (CLK_I),
    .nrst (NRST_I),
    .tif  (tif)
  );

  // ---------------------------------------------------------------------------
  // Circuit breaker
  // ---------------------------------------------------------------------------
  logic [CNT_W-1:0] oc_cnt;
  logic [CNT_W-1:0] next_oc_cnt;
  logic             tripped;
  logic             next_tripped;

  always_comb
  begin
    next_oc_cnt  = '0;
    next_tripped = tripped;
    if (over_cur && supply_ok)
    begin
      next_oc_cnt = (oc_cnt > CNT_W'(QUAL_CYC)) ? oc_cnt : oc_cnt + 32'h1;
    end
    // Trip must win over a clear arriving in the same cycle
    if (over_cur && supply_ok && oc_cnt >= CNT_W'(QUAL_CYC))
    begin
      next_tripped = 1'b1;
    end
    else if (!on_hard || !supply_ok)
    begin
      next_tripped = 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      oc_cnt  <= '0;
      tripped <= 1'b0;
    end
    else
    begin
      oc_cnt  <= next_oc_cnt;
      tripped <= next_tripped;
    end
  end

  // ---------------------------------------------------------------------------
  // Gate sequencing
  // ---------------------------------------------------------------------------
  dss_gate_t  gate_st;
  dss_gate_t  next_gate_st;
  logic       owner_gate;
  logic       next_owner_gate;
  logic       rst_rel;
  logic       next_rst_rel;
  logic       hard_off;
  logic       force_off;
  logic       gate_wait;
  logic       rst_wait;
  logic       tmr_active;

  // Breaker, lockout and hard-off all pull both gates fast
  assign hard_off   = !supply_ok || tripped || !on_hard;
  // The edge that sets the breaker drops the gates too, not one later
  assign force_off  = hard_off || next_tripped;
  assign gate_wait  = (gate_st == GATE_WAIT) && !hard_off;
  // Gate delay has priority; reset delay waits for the timer to be free
  assign rst_wait   = sense_filt && syn[SYN_SNS_OK] && on_low && supply_ok && !rst_rel && !gate_wait;
  assign tmr_active = gate_wait || rst_wait;
  // Idle or a change of owner restarts the count from zero
  assign tif.clear  = !tmr_active || (gate_wait != owner_gate);

  always_comb
  begin
    next_gate_st    = gate_st;
    next_owner_gate = gate_wait;
    unique case (gate_st)
      GATE_IDLE:
      begin
        if (on_low && !hard_off)
        begin
          next_gate_st = GATE_WAIT;
        end
      end
      GATE_WAIT:
      begin
        if (tif.done && owner_gate)
        begin
          next_gate_st = GATE_ON;
        end
      end
      GATE_ON:
      begin
        next_gate_st = GATE_ON;
      end
      // Fourth code of the two-bit state is unused
      default:
      begin
        next_gate_st = GATE_IDLE;
      end
    endcase
    if (hard_off || !on_low)
    begin
      next_gate_st = GATE_IDLE;
    end
  end

  // Owner is registered so a hand-over clears the count for one cycle
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      gate_st    <= GATE_IDLE;
      owner_gate <= 1'b0;
    end
    else
    begin
      gate_st    <= next_gate_st;
      owner_gate <= next_owner_gate;
    end
  end

  // ---------------------------------------------------------------------------
  // Channel drives
  // ---------------------------------------------------------------------------
  dss_drive_t next_ch1;
  dss_drive_t next_ch2;

  // Ramp down is the gentle pull; only breaker, lockout and hard-off use the fast one
  always_comb
  begin
    if (force_off)
    begin
      next_ch1 = DRV_OFF_FAST;
      next_ch2 = DRV_OFF_FAST;
    end
    else
    begin
      next_ch1 = (gate_st == GATE_ON && on_low) ? DRV_RAMP_UP : DRV_RAMP_DOWN;
      next_ch2 = (gate_st == GATE_ON && on_high) ? DRV_RAMP_UP : DRV_RAMP_DOWN;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      CHANNEL1_DRIVE_O <= DRV_OFF_FAST;
      CHANNEL2_DRIVE_O <= DRV_OFF_FAST;
    end
    else
    begin
      CHANNEL1_DRIVE_O <= next_ch1;
      CHANNEL2_DRIVE_O <= next_ch2;
    end
  end

  // ---------------------------------------------------------------------------
  // Reset and fault outputs
  // ---------------------------------------------------------------------------
  logic next_fault_n;

  // Release only on a done pulse that the reset delay owns
  always_comb
  begin
    next_rst_rel = rst_rel;
    next_fault_n = !next_tripped;
    if (!supply_ok || !sense_filt)
    begin
      next_rst_rel = 1'b0;
    end
    else if (rst_wait && !owner_gate && tif.done)
    begin
      next_rst_rel = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      rst_rel   <= 1'b0;
      RESET_N_O <= 1'b0;
      FAULT_N_O <= 1'b1;
    end
    else
    begin
      rst_rel   <= next_rst_rel;
      RESET_N_O <= next_rst_rel;
      FAULT_N_O <= next_fault_n;
    end
  end

endmodule : dss_sequencer

// >>> dss_plant.sv
// Purpose: Far side model: pass transistor and output monitor
// Assumes: Output comes up a few cycles after channel 2 ramps
// Notes:   dip_i lets the bench pull the sensed output low
`timescale 1ns/1ps
module dss_plant
  import dss_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  nrst_i,
  input  dss_drive_t drive_i,
  input  wire logic  dip_i,
  output logic       sense_o
);
  logic [3:0] up_cnt;

  // No drive means no output, so sense follows the gate state
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      up_cnt <= 4'h0;
    else if (drive_i != DRV_RAMP_UP)
      up_cnt <= 4'h0;
    else if (up_cnt != 4'h3)
      up_cnt <= up_cnt + 4'h1;
  end

  assign sense_o = (up_cnt == 4'h3) && !dip_i;
endmodule : dss_plant

// >>> dss_sequencer_chk.sv
// Purpose: Port-level checks of the dual supply sequencer
// Assumes: Three edge input latency
// Notes:   Run counters measure how long a raw input has held
`timescale 1ns/1ps
module dss_sequencer_chk
  import dss_pkg::*;
#(
  parameter longint unsigned TIMER_CYCLES   = TIMER_CYC,
  parameter int unsigned     FILT_SHORT_CYC = FILT_DEEP_CYC,
  parameter int unsigned     QUAL_CYC       = BRK_QUAL_CYC
)(
  input wire logic  CLK_I,
  input wire logic  NRST_I,
  input wire logic  ON_HARD_I,
  input wire logic  ON_LOW_I,
  input wire logic  OUTPUT_SENSE_INPUT_I,
  input wire logic  CURRENT_MONITOR_INPUT1_I,
  input wire logic  CURRENT_MONITOR_INPUT2_I,
  input wire logic  SUPPLY_RAIL_OK_I,
  input dss_drive_t CHANNEL1_DRIVE_O,
  input dss_drive_t CHANNEL2_DRIVE_O,
  input wire logic  RESET_N_O,
  input wire logic  FAULT_N_O
);
  logic [31:0] on_run;
  logic [31:0] oc_run;
  logic [31:0] sns_run;
  logic [31:0] low_run;
  logic        oc;
  logic        off2;

  assign oc   = CURRENT_MONITOR_INPUT1_I || CURRENT_MONITOR_INPUT2_I;
  assign off2 = (CHANNEL1_DRIVE_O == DRV_OFF_FAST) && (CHANNEL2_DRIVE_O == DRV_OFF_FAST);

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      on_run  <= '0;
      oc_run  <= '0;
      sns_run <= '0;
      low_run <= '0;
    end
    else
    begin
      on_run  <= (ON_HARD_I && ON_LOW_I) ? on_run + 32'h1 : '0;
      oc_run  <= oc ? oc_run + 32'h1 : '0;
      sns_run <= OUTPUT_SENSE_INPUT_I ? sns_run + 32'h1 : '0;
      low_run <= !OUTPUT_SENSE_INPUT_I ? low_run + 32'h1 : '0;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  property p_hard_off;
    !ON_HARD_I [*3] |=> off2;
  endproperty
  a_hard_off: assert property (p_hard_off) else $error("drives not off below hard-off");
  property p_lockout;
    !SUPPLY_RAIL_OK_I [*3] |=> off2 && !RESET_N_O;
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout not honoured");
  property p_trip_off;
    $fell(FAULT_N_O) |-> off2;
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("trip left a drive on");
  property p_fault_rel;
    (!ON_HARD_I && !oc) [*3] |=> FAULT_N_O;
  endproperty
  a_fault_rel: assert property (p_fault_rel) else $error("fault not released");
  property p_trip_qual;
    $fell(FAULT_N_O) |-> oc_run >= QUAL_CYC;
  endproperty
  a_trip_qual: assert property (p_trip_qual) else $error("trip before qualification");
  property p_gate_delay;
    (CHANNEL1_DRIVE_O == DRV_RAMP_UP) && ($past(CHANNEL1_DRIVE_O) != DRV_RAMP_UP) |-> 64'(on_run) >= TIMER_CYCLES;
  endproperty
  a_gate_delay: assert property (p_gate_delay) else $error("channel 1 up too early");
  property p_ch2_order;
    CHANNEL2_DRIVE_O == DRV_RAMP_UP |-> CHANNEL1_DRIVE_O == DRV_RAMP_UP;
  endproperty
  a_ch2_order: assert property (p_ch2_order) else $error("channel 2 up without delay");
  property p_soft_down;
    (ON_HARD_I && !ON_LOW_I && SUPPLY_RAIL_OK_I && FAULT_N_O) [*3] |=>
      (CHANNEL1_DRIVE_O == DRV_RAMP_DOWN) && (CHANNEL2_DRIVE_O == DRV_RAMP_DOWN);
  endproperty
  a_soft_down: assert property (p_soft_down) else $error("drives not ramping down");
  property p_release;
    $rose(RESET_N_O) |-> 64'(sns_run) >= TIMER_CYCLES;
  endproperty
  a_release: assert property (p_release) else $error("reset released early");
  // Lockout reaches the reset output three edges after the supply pin
  property p_filter;
    $fell(RESET_N_O) |-> (low_run >= FILT_SHORT_CYC) || !$past(SUPPLY_RAIL_OK_I, 3);
  endproperty
  a_filter: assert property (p_filter) else $error("reset fell on a short dip");

  c_release: cover property ($rose(RESET_N_O));
  c_trip: cover property ($fell(FAULT_N_O));
  c_ch2_up: cover property (CHANNEL2_DRIVE_O == DRV_RAMP_UP);
endmodule : dss_sequencer_chk

// >>> dss_sequencer_tb.sv
// Purpose: Self-checking bench for the dual supply sequencer
// Assumes: Shortened counts, inputs change on falling edges
// Notes:   Three edges from an input change to a drive change
`timescale 1ns/1ps
module dss_sequencer_tb;
  import dss_pkg::*;
  localparam longint unsigned TCYC = 20;
  localparam int unsigned     FSH  = 4;
  localparam int unsigned     FLG  = 8;
  localparam int unsigned     QCYC = 5;

  logic       clk  = 1'b0;
  logic       nrst = 1'b0;
  logic       hard = 1'b0;
  logic       low  = 1'b0;
  logic       high = 1'b0;
  logic       deep = 1'b1;
  logic       dip  = 1'b0;
  logic       cur1 = 1'b0;
  logic       cur2 = 1'b0;
  logic       sup  = 1'b1;
  logic       sense;
  logic       rst_n;
  logic       flt_n;
  dss_drive_t ch1;
  dss_drive_t ch2;
  int         failures = 0;
  int         comparisons = 0;
  int         n;

  dss_sequencer #(.TIMER_CYCLES(TCYC), .FILT_SHORT_CYC(FSH), .FILT_LONG_CYC(FLG), .QUAL_CYC(QCYC)) i_dss_sequencer (
    .CLK_I(clk), .NRST_I(nrst), .ON_HARD_I(hard), .ON_LOW_I(low), .ON_HIGH_I(high),
    .OUTPUT_SENSE_INPUT_I(sense), .SENSE_DIP_DEEP_I(deep), .CURRENT_MONITOR_INPUT1_I(cur1),
    .CURRENT_MONITOR_INPUT2_I(cur2), .SUPPLY_RAIL_OK_I(sup), .CHANNEL1_DRIVE_O(ch1),
    .CHANNEL2_DRIVE_O(ch2), .RESET_N_O(rst_n), .FAULT_N_O(flt_n));
  dss_plant i_dss_plant (.clk_i(clk), .nrst_i(nrst), .drive_i(ch2), .dip_i(dip), .sense_o(sense));

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic ticks(input int k);
    repeat (k) @(negedge clk);
  endtask : ticks

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  function automatic logic [1:0] pick(input int s);
    case (s)
      0: return ch1;
      1: return ch2;
      2: return {1'b0, rst_n};
      default: return {1'b0, flt_n};
    endcase
  endfunction : pick

  // Bounded poll; a hang ends the run
  task automatic await(input int s, input logic [1:0] want, input int bound, output int cnt);
    cnt = 0;
    while (pick(s) !== want)
    begin
      if (cnt == bound)
      begin
        check("wait bound", 1'b0, 1'b1);
        wrap_up();
      end
      ticks(1);
      cnt++;
    end
  endtask : await

  task automatic wrap_up;
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic power_up;
    check("ch1 idle", ch1, DRV_OFF_FAST);
    check("ch2 idle", ch2, DRV_OFF_FAST);
    check("reset idle", rst_n, 1'b0);
    hard = 1'b1;
    low  = 1'b1;
    await(0, DRV_RAMP_UP, TCYC + 10, n);
    check("ch1 delay", n >= TCYC, 1'b1);
    check("ch2 waits", ch2, DRV_RAMP_DOWN);
    high = 1'b1;
    await(1, DRV_RAMP_UP, 6, n);
    check("ch2 prompt", n <= 3, 1'b1);
    await(2, 2'h1, TCYC + 12, n);
    check("release delay", n >= TCYC, 1'b1);
  endtask : power_up

  task automatic dips;
    dip = 1'b1;
    ticks(FSH - 1);
    dip = 1'b0;
    ticks(8);
    check("deep short dip", rst_n, 1'b1);
    deep = 1'b0;
    dip  = 1'b1;
    ticks(FLG - 2);
    dip = 1'b0;
    ticks(10);
    check("shallow dip", rst_n, 1'b1);
    deep = 1'b1;
    dip  = 1'b1;
    await(2, 2'h0, FSH + 8, n);
    check("deep long dip", n >= FSH, 1'b1);
    dip = 1'b0;
    ticks(10);
    dip = 1'b1;
    ticks(FSH + 4);
    check("abandoned delay", rst_n, 1'b0);
    dip = 1'b0;
    await(2, 2'h1, TCYC + 12, n);
    check("restarted delay", n >= TCYC, 1'b1);
  endtask : dips

  task automatic ramp_down;
    high = 1'b0;
    ticks(3);
    check("ch2 soft", ch2, DRV_RAMP_DOWN);
    check("ch1 kept", ch1, DRV_RAMP_UP);
    await(2, 2'h0, FSH + 12, n);
    low = 1'b0;
    ticks(3);
    check("ch1 soft", ch1, DRV_RAMP_DOWN);
    hard = 1'b0;
    ticks(3);
    check("ch1 hard off", ch1, DRV_OFF_FAST);
    check("ch2 hard off", ch2, DRV_OFF_FAST);
  endtask : ramp_down

  task automatic breaker;
    {hard, low, high} = 3'h7;
    await(1, DRV_RAMP_UP, TCYC + 12, n);
    cur1 = 1'b1;
    ticks(QCYC - 2);
    cur1 = 1'b0;
    ticks(8);
    check("short surge", flt_n, 1'b1);
    cur2 = 1'b1;
    await(3, 2'h0, QCYC + 8, n);
    check("trip time", n >= QCYC, 1'b1);
    check("trip ch1", ch1, DRV_OFF_FAST);
    check("trip ch2", ch2, DRV_OFF_FAST);
    cur2 = 1'b0;
    ticks(TCYC + 8);
    check("latched ch2", ch2, DRV_OFF_FAST);
    check("latched fault", flt_n, 1'b0);
    {hard, low, high} = 3'h0;
    await(3, 2'h1, 5, n);
    {hard, low, high} = 3'h7;
    await(0, DRV_RAMP_UP, TCYC + 10, n);
    check("new cycle", n >= TCYC, 1'b1);
  endtask : breaker

  task automatic lockout;
    await(2, 2'h1, TCYC + 16, n);
    sup = 1'b0;
    ticks(3);
    check("lockout ch1", ch1, DRV_OFF_FAST);
    check("lockout ch2", ch2, DRV_OFF_FAST);
    check("lockout reset", rst_n, 1'b0);
    sup = 1'b1;
    // Let the lockout assertions see their closing edge
    ticks(4);
    check("lockout reset held", rst_n, 1'b0);
  endtask : lockout

  initial
  begin
    ticks(2);
    nrst = 1'b1;
    ticks(1);
    power_up();
    dips();
    ramp_down();
    breaker();
    lockout();
    wrap_up();
  end
endmodule : dss_sequencer_tb

bind dss_sequencer dss_sequencer_chk #(.TIMER_CYCLES(TIMER_CYCLES), .FILT_SHORT_CYC(FILT_SHORT_CYC),
  .QUAL_CYC(QUAL_CYC)) i_dss_sequencer_chk (.CLK_I(CLK_I), .NRST_I(NRST_I), .ON_HARD_I(ON_HARD_I),
  .ON_LOW_I(ON_LOW_I), .OUTPUT_SENSE_INPUT_I(OUTPUT_SENSE_INPUT_I),
  .CURRENT_MONITOR_INPUT1_I(CURRENT_MONITOR_INPUT1_I), .CURRENT_MONITOR_INPUT2_I(CURRENT_MONITOR_INPUT2_I),
  .SUPPLY_RAIL_OK_I(SUPPLY_RAIL_OK_I), .CHANNEL1_DRIVE_O(CHANNEL1_DRIVE_O), .CHANNEL2_DRIVE_O(CHANNEL2_DRIVE_O),
  .RESET_N_O(RESET_N_O), .FAULT_N_O(FAULT_N_O));
